// ===== verilog/i2c_seq_params.svh
// Offsets, field positions, reset values and timing counts of the sequencer.
// Assumes inclusion by bare name from the verilog/ folder.
`ifndef I2C_SEQ_PARAMS_SVH
`define I2C_SEQ_PARAMS_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define REG_AW      3
`define REG_CTL2    3'h0
`define REG_STAT    3'h1
`define REG_BUF     3'h2
`define REG_BAUD    3'h3
`define REG_FLAG    3'h4

// ----------------------------------------
// Field positions
// ----------------------------------------
`define CTL_SEN     0
`define CTL_REP_START_ENABLE    1
`define CTL_RECEIVE_ENABLE    3
`define CTL_ACK_SEQ_ENABLE   4
`define CTL_ACK_DATA   5
`define CTL_ACKST   6
`define STA_BF      0
`define STA_S       3
`define FLG_IRQ     0
`define FLG_BCL     1
`define FLG_OVF     6
`define FLG_WRITE_COLLISION_FLAG    7

// ----------------------------------------
// Reset values and timing
// ----------------------------------------
`define BAUD_RST    8'h00
`define BUF_RST     8'h00
`define BAUD_W      7
`define TICK_PHASES 4
`define LAST_TX_BIT 4'h8
`define LAST_RX_BIT 4'h7

`endif

// ===== verilog/i2c_seq_pkg.sv
// Types shared by the sequencer modules.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none
package i2c_seq_pkg;

	// ----------------------------------------
	// Sequencer states
	// ----------------------------------------
	typedef enum logic [4:0] {
		ST_IDLE    = 5'b00000,
		ST_WAIT    = 5'b00001,
		ST_HOLD    = 5'b00010,
		RS_SCL_LOW = 5'b00011,
		RS_SDA_HI  = 5'b00100,
		RS_SCL_REL = 5'b00101,
		RS_SCL_HI  = 5'b00110,
		RS_SDA_LOW = 5'b00111,
		TX_LOW     = 5'b01000,
		TX_HWAIT   = 5'b01001,
		TX_HIGH    = 5'b01010,
		RX_LOW     = 5'b01011,
		RX_HWAIT   = 5'b01100,
		RX_HIGH    = 5'b01101,
		ACK_LOW    = 5'b01110,
		ACK_HWAIT  = 5'b01111,
		ACK_HIGH   = 5'b10000
	} seq_state_t;

	typedef logic [7:0] byte_t;

endpackage : i2c_seq_pkg

`default_nettype wire

// ===== verilog/baud_if.sv
// Carrier between the sequencer and its baud counter.
// Assumes both ends share one clock.
`timescale 1ns/1ps
`default_nettype none
`include "i2c_seq_params.svh"

interface baud_if;
	logic                load;
	logic                halt;
	logic [`BAUD_W-1:0]  reload;
	logic                expire;

	modport ctl (output load, output halt, output reload, input expire);
	modport cnt (input load, input halt, input reload, output expire);
endinterface : baud_if

`default_nettype wire

// ===== verilog/baud_counter.sv
// Reloadable down counter that times every SCL phase.
// Assumes the controller loads it only while it holds halt low.
`timescale 1ns/1ps
`default_nettype none
`include "i2c_seq_params.svh"

module baud_counter
	import i2c_seq_pkg::*;
#(
	parameter int W      = `BAUD_W,
	parameter int PHASES = `TICK_PHASES
) (
	// Clock and reset
	input  wire logic clk_in,
	input  wire logic rstn_in,
	input  wire logic ce_in,
	// Controller side
	baud_if.cnt       bif
);
	if (W != `BAUD_W || PHASES < 2 || PHASES % 2 != 0) begin : g_chk
		$error("baud_counter: unsupported W or PHASES");
	end

	localparam int PW = $clog2(PHASES);

	logic [PW-1:0] phase_ff;
	logic [W-1:0]  cnt_ff;
	logic          run_ff;
	logic          tick;

	// ----------------------------------------
	// Quarter phases: two decrements per cycle
	// ----------------------------------------
	assign tick = phase_ff[0];

	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			phase_ff <= '0;
		end else if (ce_in) begin
			phase_ff <= (phase_ff == PW'(PHASES - 1)) ? '0 : phase_ff + PW'(1);
		end
	end

	// ----------------------------------------
	// Count down to zero, then stop
	// ----------------------------------------
	assign bif.expire = run_ff && tick && (cnt_ff == '0);

	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			cnt_ff <= '0;
			run_ff <= 1'b0;
		end else if (ce_in) begin
			if (bif.halt) begin
				run_ff <= 1'b0;
			end else if (bif.load) begin
				cnt_ff <= bif.reload;
				run_ff <= 1'b1;
			end else if (run_ff && tick) begin
				if (cnt_ff == '0) begin
					run_ff <= 1'b0;
				end else begin
					cnt_ff <= cnt_ff - W'(1);
				end
			end
		end
	end

endmodule : baud_counter

`default_nettype wire

// ===== verilog/i2c_master_sequencer.sv
// I2C master condition and byte sequencer with a small register port.
// Assumes open-drain pads with pull-ups; SDA and SCL arrive asynchronously.
// Functional notes
// - Start enable with idle lines loads counter
// - Expiry with lines high drives SDA low
// - Second expiry clears start enable, holds SDA
// - Start collision sets flag, returns idle
// - Buffer write during condition sets write collision
// - Control low bits locked until condition completes
// - Repeated start pulls SCL, releases SDA
// - SCL released if SDA high, SDA low
// - Start seen early, irq after expiry
// - Repeated start ignored while busy
// - Repeated start collision on three cases
// - Buffer write sets full, starts shifting
// - Bit after SCL fall, low then high
// - Full clears after eighth bit, SDA released
// - Ninth fall samples acknowledge into status
// - After ninth clock irq, SCL held low
// - Write while shifting refused, flag software cleared
// - Receive toggles SCL, samples SDA high
// - Eighth receive fall loads buffer, flags, idle
// - Buffer read clears full; overflow flagged
// - Acknowledge sequence drives data for one clock
// - Counter reloads seven bits, stops at zero
// - Counter decrements twice per instruction cycle
// - Released SCL pauses counter until sampled high
`timescale 1ns/1ps
`default_nettype none
`include "i2c_seq_params.svh"

module i2c_master_sequencer
	import i2c_seq_pkg::*;
(
	// Clock, reset, enable
	input  wire logic              clk_in,
	input  wire logic              rstn_in,
	input  wire logic              ce_in,
	// Register port
	input  wire logic [`REG_AW-1:0] addr_in,
	input  wire logic [7:0]        wdata_in,
	input  wire logic              wr_in,
	input  wire logic              rd_in,
	output logic      [7:0]        rdata_out,
	// I2C lines
	input  wire logic              sda_in,
	output logic                   sda_out,
	output logic                   sda_oe_out,
	input  wire logic              scl_in,
	output logic                   scl_out,
	output logic                   scl_oe_out
);
	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	seq_state_t  state_ff;
	logic        sda_meta_ff, sda_s_ff, sda_prev_ff;
	logic        scl_meta_ff, scl_s_ff;
	logic        sda_drv_ff, scl_drv_ff, load_ff;
	logic [3:0]  bit_ff;
	byte_t       shift_ff, buf_ff, baud_ff, rdata_ff;
	logic        sen_ff, rep_start_enable_ff, receive_enable_ff, ack_seq_enable_ff, ack_data_ff, ackst_ff;
	logic        bf_ff, s_ff, irq_ff, bcl_ff, ovf_ff, write_collision_flag_ff;
	logic        idle, pending, lock, exp, bcl;
	logic        buf_wr, buf_wr_ok, buf_rd;
	logic        ev_st_done, ev_rs_done, ev_tx8, ev_tx_done;
	logic        ev_rx_done, ev_ack_done, ev_irq;

	baud_if bif ();

	function automatic logic hit(input logic [`REG_AW-1:0] a,
		input logic [`REG_AW-1:0] off);
		hit = (a == off);
	endfunction : hit

	baud_counter u_baud (
		.clk_in  (clk_in),
		.rstn_in (rstn_in),
		.ce_in   (ce_in),
		.bif     (bif)
	);

	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			sda_meta_ff <= 1'b1;
			sda_s_ff    <= 1'b1;
			sda_prev_ff <= 1'b1;
			scl_meta_ff <= 1'b1;
			scl_s_ff    <= 1'b1;
		end else if (ce_in) begin
			sda_meta_ff <= sda_in;
			sda_s_ff    <= sda_meta_ff;
			sda_prev_ff <= sda_s_ff;
			scl_meta_ff <= scl_in;
			scl_s_ff    <= scl_meta_ff;
		end
	end

	// ----------------------------------------
	// Events
	// ----------------------------------------
	assign idle       = (state_ff == ST_IDLE);
	assign exp        = bif.expire;
	assign pending    = sen_ff | rep_start_enable_ff | receive_enable_ff | ack_seq_enable_ff;
	assign lock       = !idle || pending;
	assign buf_wr     = wr_in && hit(addr_in, `REG_BUF);
	assign buf_rd     = rd_in && hit(addr_in, `REG_BUF);
	assign buf_wr_ok  = buf_wr && idle && !pending;
	assign ev_st_done = (state_ff == ST_HOLD) && exp;
	assign ev_rs_done = (state_ff == RS_SDA_LOW) && exp;
	assign ev_tx8     = (state_ff == TX_HIGH) && exp && (bit_ff == `LAST_RX_BIT);
	assign ev_tx_done = (state_ff == TX_HIGH) && exp && (bit_ff == `LAST_TX_BIT);
	assign ev_rx_done = (state_ff == RX_HIGH) && exp && (bit_ff == `LAST_RX_BIT);
	assign ev_ack_done = (state_ff == ACK_HIGH) && exp;
	assign ev_irq     = ev_st_done | ev_rs_done | ev_tx_done | ev_rx_done | ev_ack_done;

	// Collisions abort whatever runs and release both lines
	assign bcl = (idle && sen_ff && !(sda_s_ff && scl_s_ff))
		|| (state_ff == ST_WAIT && !scl_s_ff)
		|| (state_ff == RS_SDA_HI && exp && !sda_s_ff)
		|| (state_ff == RS_SCL_REL && scl_s_ff && !sda_s_ff)
		|| (state_ff == RS_SCL_HI && !scl_s_ff)
		|| (state_ff == TX_HIGH && !sda_drv_ff && !sda_s_ff && bit_ff < `LAST_TX_BIT);

	// ----------------------------------------
	// Baud counter control
	// ----------------------------------------
	assign bif.load   = load_ff;
	assign bif.halt   = idle;
	assign bif.reload = baud_ff[`BAUD_W-1:0];

	// ----------------------------------------
	// Sequencer
	// ----------------------------------------
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			state_ff   <= ST_IDLE;
			sda_drv_ff <= 1'b0;
			scl_drv_ff <= 1'b0;
			load_ff    <= 1'b0;
			bit_ff     <= 4'h0;
			shift_ff   <= 8'h00;
		end else if (ce_in) begin
			load_ff <= 1'b0;
			if (bcl) begin
				state_ff   <= ST_IDLE;
				sda_drv_ff <= 1'b0;
				scl_drv_ff <= 1'b0;
			end else begin
				unique case (state_ff)
				ST_IDLE: begin
					if (sen_ff) begin
						load_ff  <= 1'b1;
						state_ff <= ST_WAIT;
					end else if (rep_start_enable_ff) begin
						scl_drv_ff <= 1'b1;
						state_ff   <= RS_SCL_LOW;
					end else if (receive_enable_ff) begin
						sda_drv_ff <= 1'b0;
						scl_drv_ff <= 1'b1;
						bit_ff     <= 4'h0;
						load_ff    <= 1'b1;
						state_ff   <= RX_LOW;
					end else if (ack_seq_enable_ff) begin
						scl_drv_ff <= 1'b1;
						sda_drv_ff <= !ack_data_ff;
						load_ff    <= 1'b1;
						state_ff   <= ACK_LOW;
					end else if (buf_wr_ok) begin
						shift_ff   <= wdata_in;
						sda_drv_ff <= !wdata_in[7];
						scl_drv_ff <= 1'b1;
						bit_ff     <= 4'h0;
						load_ff    <= 1'b1;
						state_ff   <= TX_LOW;
					end
				end
				ST_WAIT: begin
					// SDA pulled early by another master just starts sooner
					if (exp || !sda_s_ff) begin
						sda_drv_ff <= 1'b1;
						load_ff    <= 1'b1;
						state_ff   <= ST_HOLD;
					end
				end
				ST_HOLD: begin
					if (exp) begin
						scl_drv_ff <= 1'b1;
						state_ff   <= ST_IDLE;
					end
				end
				RS_SCL_LOW: begin
					if (!scl_s_ff) begin
						sda_drv_ff <= 1'b0;
						load_ff    <= 1'b1;
						state_ff   <= RS_SDA_HI;
					end
				end
				RS_SDA_HI: begin
					if (exp && sda_s_ff) begin
						scl_drv_ff <= 1'b0;
						state_ff   <= RS_SCL_REL;
					end
				end
				RS_SCL_REL: begin
					if (scl_s_ff) begin
						load_ff  <= 1'b1;
						state_ff <= RS_SCL_HI;
					end
				end
				RS_SCL_HI: begin
					if (exp) begin
						sda_drv_ff <= 1'b1;
						load_ff    <= 1'b1;
						state_ff   <= RS_SDA_LOW;
					end
				end
				RS_SDA_LOW: begin
					if (exp) begin
						scl_drv_ff <= 1'b1;
						state_ff   <= ST_IDLE;
					end
				end
				TX_LOW: begin
					// New bit only once SCL is already low; the ninth slot floats for the slave
					if (load_ff) begin
						sda_drv_ff <= (bit_ff == `LAST_TX_BIT) ? 1'b0 : !shift_ff[7];
					end
					if (exp) begin
						scl_drv_ff <= 1'b0;
						state_ff   <= TX_HWAIT;
					end
				end
				TX_HWAIT: begin
					if (scl_s_ff) begin
						load_ff  <= 1'b1;
						state_ff <= TX_HIGH;
					end
				end
				TX_HIGH: begin
					if (exp) begin
						scl_drv_ff <= 1'b1;
						if (bit_ff == `LAST_TX_BIT) begin
							sda_drv_ff <= 1'b0;
							state_ff   <= ST_IDLE;
						end else begin
							shift_ff   <= {shift_ff[6:0], 1'b0};
							bit_ff     <= bit_ff + 4'h1;
							load_ff    <= 1'b1;
							state_ff   <= TX_LOW;
						end
					end
				end
				RX_LOW: begin
					if (exp) begin
						scl_drv_ff <= 1'b0;
						state_ff   <= RX_HWAIT;
					end
				end
				RX_HWAIT: begin
					if (scl_s_ff) begin
						shift_ff <= {shift_ff[6:0], sda_s_ff};
						load_ff  <= 1'b1;
						state_ff <= RX_HIGH;
					end
				end
				RX_HIGH: begin
					if (exp) begin
						scl_drv_ff <= 1'b1;
						if (bit_ff == `LAST_RX_BIT) begin
							state_ff <= ST_IDLE;
						end else begin
							bit_ff   <= bit_ff + 4'h1;
							load_ff  <= 1'b1;
							state_ff <= RX_LOW;
						end
					end
				end
				ACK_LOW: begin
					if (exp) begin
						scl_drv_ff <= 1'b0;
						state_ff   <= ACK_HWAIT;
					end
				end
				ACK_HWAIT: begin
					if (scl_s_ff) begin
						load_ff  <= 1'b1;
						state_ff <= ACK_HIGH;
					end
				end
				ACK_HIGH: begin
					if (exp) begin
						scl_drv_ff <= 1'b1;
						state_ff   <= ST_IDLE;
					end
				end
				default: state_ff <= ST_IDLE;
				endcase
			end
		end
	end

	// ----------------------------------------
	// Second control register
	// ----------------------------------------
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			sen_ff   <= 1'b0;
			rep_start_enable_ff  <= 1'b0;
			receive_enable_ff  <= 1'b0;
			ack_seq_enable_ff <= 1'b0;
			ack_data_ff <= 1'b0;
			ackst_ff <= 1'b0;
		end else if (ce_in) begin
			if (wr_in && hit(addr_in, `REG_CTL2)) begin
				ack_data_ff <= wdata_in[`CTL_ACK_DATA];
				if (!lock) begin
					// Enables only land while idle, so nothing queues
					sen_ff   <= wdata_in[`CTL_SEN];
					rep_start_enable_ff  <= wdata_in[`CTL_REP_START_ENABLE];
					receive_enable_ff  <= wdata_in[`CTL_RECEIVE_ENABLE];
					ack_seq_enable_ff <= wdata_in[`CTL_ACK_SEQ_ENABLE];
				end
			end
			if (ev_st_done || bcl) begin
				sen_ff <= 1'b0;
			end
			if (ev_rs_done || bcl) begin
				rep_start_enable_ff <= 1'b0;
			end
			if (ev_rx_done || bcl) begin
				receive_enable_ff <= 1'b0;
			end
			if (ev_ack_done || bcl) begin
				ack_seq_enable_ff <= 1'b0;
			end
			if (ev_tx_done) begin
				ackst_ff <= sda_s_ff;
			end
		end
	end

	// ----------------------------------------
	// Buffer and status
	// ----------------------------------------
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			buf_ff  <= `BUF_RST;
			baud_ff <= `BAUD_RST;
		end else if (ce_in) begin
			if (buf_wr_ok) begin
				buf_ff <= wdata_in;
			end else if (ev_rx_done) begin
				buf_ff <= shift_ff;
			end
			if (wr_in && hit(addr_in, `REG_BAUD)) begin
				baud_ff <= wdata_in;
			end
		end
	end

	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			bf_ff <= 1'b0;
		end else if (ce_in) begin
			if (buf_wr_ok || ev_rx_done) begin
				bf_ff <= 1'b1;
			end else if (ev_tx8 || buf_rd || bcl) begin
				bf_ff <= 1'b0;
			end
		end
	end

	// Start seen clears again once a stop shows on the lines
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			s_ff <= 1'b0;
		end else if (ce_in) begin
			if (sda_prev_ff && !sda_s_ff && scl_s_ff) begin
				s_ff <= 1'b1;
			end else if (!sda_prev_ff && sda_s_ff && scl_s_ff) begin
				s_ff <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// Event flags: a set wins over a write
	// ----------------------------------------
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			irq_ff  <= 1'b0;
			bcl_ff  <= 1'b0;
			ovf_ff  <= 1'b0;
			write_collision_flag_ff <= 1'b0;
		end else if (ce_in) begin
			if (wr_in && hit(addr_in, `REG_FLAG)) begin
				irq_ff  <= wdata_in[`FLG_IRQ];
				bcl_ff  <= wdata_in[`FLG_BCL];
				ovf_ff  <= wdata_in[`FLG_OVF];
				write_collision_flag_ff <= wdata_in[`FLG_WRITE_COLLISION_FLAG];
			end
			if (ev_irq) begin
				irq_ff <= 1'b1;
			end
			if (bcl) begin
				bcl_ff <= 1'b1;
			end
			if (ev_rx_done && bf_ff) begin
				ovf_ff <= 1'b1;
			end
			if (buf_wr && !buf_wr_ok) begin
				write_collision_flag_ff <= 1'b1;
			end
		end
	end

	// ----------------------------------------
	// Read port: data stand one cycle later
	// ----------------------------------------
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			rdata_ff <= 8'h00;
		end else if (ce_in) begin
			rdata_ff <= 8'h00;
			if (rd_in) begin
				unique case (addr_in)
				`REG_CTL2: rdata_ff <= {1'b0, ackst_ff, ack_data_ff, ack_seq_enable_ff, receive_enable_ff, 1'b0, rep_start_enable_ff, sen_ff};
				`REG_STAT: rdata_ff <= {4'h0, s_ff, 2'b00, bf_ff};
				`REG_BUF:  rdata_ff <= buf_ff;
				`REG_BAUD: rdata_ff <= baud_ff;
				`REG_FLAG: rdata_ff <= {write_collision_flag_ff, ovf_ff, 4'h0, bcl_ff, irq_ff};
				default:   rdata_ff <= 8'h00;
				endcase
			end
		end
	end

	assign rdata_out  = rdata_ff;
	assign sda_out    = 1'b0;
	assign scl_out    = 1'b0;
	assign sda_oe_out = sda_drv_ff;
	assign scl_oe_out = scl_drv_ff;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rstn_in);

	a_start_sda_low: assert property (ce_in && state_ff == ST_WAIT && exp && scl_s_ff |=>
		sda_oe_out && state_ff == ST_HOLD) else $error("start did not drive SDA low");
	a_start_done: assert property (ce_in && ev_st_done && !bcl |=>
		!sen_ff && idle && sda_oe_out) else $error("start did not complete");
	a_start_bcl: assert property (ce_in && idle && sen_ff && !(sda_s_ff && scl_s_ff) |=>
		bcl_ff && !sen_ff && idle) else $error("start collision missed");
	a_write_collision_flag_busy: assert property (ce_in && buf_wr && !idle && !ev_rx_done |=>
		write_collision_flag_ff && buf_ff == $past(buf_ff)) else $error("busy buffer write not refused");
	a_tx_launch: assert property (ce_in && buf_wr_ok |=>
		bf_ff && state_ff == TX_LOW && bif.load) else $error("buffer write did not start transmit");
	a_ack_sample: assert property (ce_in && ev_tx_done && !bcl |=>
		ackst_ff == $past(sda_s_ff) && irq_ff && scl_oe_out) else $error("ack not sampled");
	a_rx_done: assert property (ce_in && ev_rx_done |=>
		buf_ff == $past(shift_ff) && bf_ff && !receive_enable_ff && idle) else $error("receive end wrong");
	a_rx_ovf: assert property (ce_in && ev_rx_done && bf_ff |=> ovf_ff)
		else $error("overflow not flagged");
	a_scl_wait: assert property (ce_in && state_ff == TX_HWAIT && !scl_s_ff |=>
		state_ff == TX_HWAIT && !bif.load) else $error("counter ran before SCL high");
	a_rs_finish: assert property (ce_in && ev_rs_done && !bcl |=>
		!rep_start_enable_ff && irq_ff && sda_oe_out) else $error("repeated start end wrong");

	c_start: cover property (ev_st_done);
	c_tx_byte: cover property (ev_tx_done);
	c_rx_byte: cover property (ev_rx_done);
	c_ack_seq: cover property (ev_ack_done);

endmodule : i2c_master_sequencer

`default_nettype wire

// ===== verification/i2c_slave_model.sv
// Behavioural slave at the far end of the sequencer's I2C pads.
// Assumes resolved open-drain wires; the bench arms each byte frame.
`timescale 1ns/1ps
`default_nettype none

module i2c_slave_model (
	// Bus wires
	input  wire logic       scl_in,
	input  wire logic       sda_in,
	// Bench controls
	input  wire logic       arm_in,
	input  wire logic       rx_in,
	input  wire logic       nack_in,
	input  wire logic       hold_in,
	input  wire logic [7:0] tx_byte_in,
	// Pad pull-down
	output logic            sda_low_out
);
	// ----------------------------------------
	// Bit framing
	// ----------------------------------------
	logic [3:0] cnt;
	logic [7:0] got;
	logic       ack_seen;

	always @(posedge arm_in or negedge scl_in) begin
		if (arm_in) cnt <= 4'h0;
		else cnt <= cnt + 4'h1;
	end

	// Data is only taken while SCL is high
	always @(posedge scl_in) begin
		if (!rx_in && cnt < 4'h8) got <= {got[6:0], sda_in};
		if (cnt == 4'h8) ack_seen <= sda_in;
	end

	// Only ever pulls low; a released line floats to the pull-up
	assign sda_low_out = hold_in || (rx_in ? (cnt < 4'h8 && !tx_byte_in[3'h7 - cnt[2:0]])
	                                       : (cnt == 4'h8 && !nack_in));
endmodule : i2c_slave_model

`default_nettype wire

// ===== verification/i2c_master_sequencer_tb.sv
// Self-checking bench for the sequencer, driven through its register port.
// Resolves SDA from the design's open-drain enable and the slave model's pull-down.
`timescale 1ns/1ps
`default_nettype none
`include "i2c_seq_params.svh"
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin mismatches++; $display("BAD %0t got %h exp %h", $time, g, e); end end

module i2c_master_sequencer_tb
	import i2c_seq_pkg::*;
;
	// ----------------------------------------
	// Signals
	// ----------------------------------------
	logic               clk_in, rstn_in, wr_in, rd_in, arm, rx, nack, hold;
	logic [`REG_AW-1:0] addr_in;
	byte_t              wdata_in, rdata_out, d, txb;
	logic               sda_out, sda_oe_out, scl_out, scl_oe_out, sl_low;
	int                 mismatches, num_checks, i;
	wire logic          sda = !(sda_oe_out || sl_low);
	wire logic          scl = !scl_oe_out;

	i2c_master_sequencer i2c_master_sequencer_inst (.clk_in(clk_in), .rstn_in(rstn_in), .ce_in(1'b1),
		.addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
		.sda_in(sda), .sda_out(sda_out), .sda_oe_out(sda_oe_out),
		.scl_in(scl), .scl_out(scl_out), .scl_oe_out(scl_oe_out));
	i2c_slave_model i2c_slave_model_inst (.scl_in(scl), .sda_in(sda), .arm_in(arm), .rx_in(rx),
		.nack_in(nack), .hold_in(hold), .tx_byte_in(txb), .sda_low_out(sl_low));

	// ----------------------------------------
	// Bus tasks
	// ----------------------------------------
	task automatic wr(input logic [`REG_AW-1:0] a, input byte_t v);
		@(posedge clk_in);
		wr_in <= 1'b1;
		addr_in <= a;
		wdata_in <= v;
		@(posedge clk_in);
		wr_in <= 1'b0;
	endtask : wr

	task automatic rd(input logic [`REG_AW-1:0] a);
		@(posedge clk_in);
		rd_in <= 1'b1;
		addr_in <= a;
		@(posedge clk_in);
		rd_in <= 1'b0;
		#1 d = rdata_out;
	endtask : rd

	task automatic chk(input logic [`REG_AW-1:0] a, input byte_t e);
		rd(a);
		`CHK(d, e)
	endtask : chk

	// Bounded wait on a field; a hang shows as a mismatch, not a stall
	task automatic poll(input logic [`REG_AW-1:0] a, input byte_t m, input byte_t v);
		for (int k = 0; k < 3000; k++) begin
			rd(a);
			if ((d & m) === v) break;
		end
		`CHK(d & m, v)
	endtask : poll

	task automatic arm_slave;
		arm = 1'b1;
		#1 arm = 1'b0;
	endtask : arm_slave

	task automatic finish_test;
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : finish_test

	// ----------------------------------------
	// Clock, reset, watchdog
	// ----------------------------------------
	initial begin
		clk_in = 1'b0;
		forever #10 clk_in = ~clk_in;
	end

	// About half a dozen byte-length operations of some 200 cycles each, with wide margin
	initial begin
		#2000000;
		mismatches++;
		finish_test();
	end

	// ----------------------------------------
	// Tests
	// ----------------------------------------
	initial begin
		{rstn_in, wr_in, rd_in, arm, rx, nack} = '0;
		{addr_in, wdata_in, txb} = '0;
		hold = 1'b0;
		@(posedge clk_in);
		arm_slave();
		repeat (9) @(posedge clk_in);
		rstn_in <= 1'b1;
		chk(`REG_CTL2, 8'h00);
		chk(`REG_STAT, 8'h00);
		chk(`REG_FLAG, 8'h00);
		chk(3'h7, 8'h00);
		hold <= 1'b1;
		wr(`REG_BAUD, 8'h03);
		wr(`REG_CTL2, 8'h01);
		poll(`REG_FLAG, 8'h02, 8'h02);
		chk(`REG_CTL2, 8'h00);
		$display("collision test done");
		hold <= 1'b0;
		wr(`REG_FLAG, 8'h00);
		repeat (4) @(posedge clk_in);
		wr(`REG_CTL2, 8'h01);
		wr(`REG_BUF, 8'h55);
		wr(`REG_CTL2, 8'h08);
		poll(`REG_CTL2, 8'hFF, 8'h00);
		chk(`REG_FLAG, 8'h81);
		chk(`REG_BUF, 8'h00);
		chk(`REG_STAT, 8'h08);
		`CHK({scl_oe_out, sda_oe_out}, 2'b11)
		`CHK({scl_out, sda_out}, 2'b00)
		$display("start test done");
		wr(`REG_FLAG, 8'h00);
		arm_slave();
		wr(`REG_BUF, 8'hA5);
		chk(`REG_STAT, 8'h09);
		wr(`REG_BUF, 8'h11);
		wr(`REG_CTL2, 8'h02);
		poll(`REG_FLAG, 8'h01, 8'h01);
		`CHK(i2c_slave_model_inst.got, 8'hA5)
		chk(`REG_FLAG, 8'h81);
		chk(`REG_CTL2, 8'h00);
		chk(`REG_STAT, 8'h08);
		`CHK({scl_oe_out, sda_oe_out}, 2'b10)
		nack <= 1'b1;
		wr(`REG_FLAG, 8'h00);
		arm_slave();
		wr(`REG_BUF, 8'h3C);
		poll(`REG_FLAG, 8'h01, 8'h01);
		chk(`REG_CTL2, 8'h40);
		$display("transmit test done");
		nack <= 1'b0;
		txb <= 8'hC3;
		rx <= 1'b1;
		#1 arm_slave();
		wr(`REG_FLAG, 8'h00);
		wr(`REG_CTL2, 8'h08);
		poll(`REG_FLAG, 8'h01, 8'h01);
		chk(`REG_STAT, 8'h09);
		chk(`REG_CTL2, 8'h40);
		chk(`REG_BUF, 8'hC3);
		chk(`REG_STAT, 8'h08);
		for (i = 0; i < 2; i++) begin
			arm_slave();
			wr(`REG_FLAG, 8'h00);
			wr(`REG_CTL2, 8'h08);
			poll(`REG_FLAG, 8'h01, 8'h01);
		end
		chk(`REG_FLAG, 8'h41);
		$display("receive test done");
		wr(`REG_FLAG, 8'h00);
		wr(`REG_CTL2, 8'h30);
		poll(`REG_FLAG, 8'h01, 8'h01);
		chk(`REG_CTL2, 8'h60);
		`CHK(scl_oe_out, 1'b1)
		`CHK(i2c_slave_model_inst.ack_seen, 1'b1)
		rx <= 1'b0;
		$display("acknowledge test done");
		wr(`REG_FLAG, 8'h00);
		wr(`REG_CTL2, 8'h22);
		poll(`REG_CTL2, 8'h02, 8'h00);
		chk(`REG_FLAG, 8'h01);
		`CHK({scl_oe_out, sda_oe_out}, 2'b11)
		$display("repeated start test done");
		finish_test();
	end
endmodule : i2c_master_sequencer_tb

`default_nettype wire
